// [include/ssc_defines.svh]
// constants of the safety status block: commands, codes, reset values, timing
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_CMD_RD_STAT3 7'h12
`define SSC_CMD_RD_STAT4 7'h13
`define SSC_CMD_RD_STAT5 7'h14
`define SSC_CMD_RD_CFG 7'h15
`define SSC_CMD_WR_CFG 7'h35
`define SSC_CMD_SOFTWARE_LOCK_COMMAND 7'h3A
`define SSC_FRAME_BITS 5'h10
`define SSC_CMD_BITS 5'h08
`define SSC_CODE_STANDBY 3'h0
`define SSC_CODE_RESET 3'h3
`define SSC_CODE_DIAG 3'h7
`define SSC_CODE_ACTIVE 3'h5
`define SSC_CODE_SAFE 3'h4
`define SSC_SPI_OK 2'h0
`define SSC_SPI_SDO 2'h1
`define SSC_SPI_FRAME 2'h3
`define SSC_CFG_RESET 8'h00
`define SSC_CFG_TO_MSB 7
`define SSC_CFG_TO_LSB 5
`define SSC_CFG_THR_MSB 4
`define SSC_CFG_THR_LSB 1
`define SSC_CFG_LOCK_BIT 0
`define SSC_WDCNT_INIT 3'h5
`define SSC_WDCNT_MAX 3'h7
`define SSC_THR_ZERO_AS 4'hF
`define SSC_CLK_MHZ 250
`define SSC_RST_DEG_US 120
`define SSC_DRV_DEG_US 32
`define SSC_SAFE_UNIT_MS 22
`define SSC_LOCK_MS 680
`define SSC_US_PER_MS 1000
`endif

// [include/ssc_pkg.sv]
// types of the safety status block
`default_nettype none
package ssc_pkg;
    typedef enum logic [2:0] {ST_STANDBY, ST_RESET, ST_DIAG, ST_ACTIVE, ST_SAFE} ssc_state_t;
    typedef struct packed {
        logic [1:0] sclk;
        logic [1:0] ncs;
        logic [1:0] mosi;
        logic [1:0] sdo_fb;
        logic [1:0] rst_fb;
        logic [1:0] drv_fb;
    } ssc_sync_t;
    typedef struct packed {
        ssc_sync_t sy;
        logic sclk_prev;
        logic [4:0] bit_cnt;
        logic [7:0] cmd;
        logic [7:0] data;
        logic [7:0] tx;
        logic sdo_bad;
        logic spi_hold;
        logic [1:0] spi_err;
        logic sdo;
        logic sdo_oe_n;
        ssc_state_t fsm;
        logic [2:0] code;
        logic [7:0] cfg;
        logic software_lock_command;
        logic [7:0] us_div;
        logic [9:0] ms_div;
        logic [9:0] safe_ms;
        logic [6:0] rst_deg;
        logic [6:0] drv_deg;
        logic rst_err;
        logic drv_err;
        logic logic_test_running;
        logic analog_test_running;
        logic logic_test_error;
        logic analog_test_error;
        logic clk_loss;
        logic mcu_err;
        logic watchdog_error_flag;
        logic trim_err;
        logic [2:0] wd_cnt;
        logic rst_out;
        logic drv_out;
    } ssc_regs_t;
endpackage : ssc_pkg
`default_nettype wire

// [rtl/ssc_safety_status.sv]
// safety status registers, safe-state timing and serial register access
`default_nettype none
`include "ssc_defines.svh"
module ssc_safety_status #(
    parameter int US_CYCLES = `SSC_CLK_MHZ,
    parameter int US_PER_MS = `SSC_US_PER_MS,
    parameter int RST_DEG_US = `SSC_RST_DEG_US,
    parameter int DRV_DEG_US = `SSC_DRV_DEG_US
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic logic_self_test_reinit,
    input wire logic spi_sclk,
    input wire logic spi_ncs_n,
    input wire logic spi_mosi,
    input wire logic sdo_readback,
    input wire logic mcu_reset_in,
    input wire logic drive_enable_in,
    input wire logic wake,
    input wire logic reset_done,
    input wire logic diag_exit,
    input wire logic safe_request,
    input wire logic drive_request,
    input wire logic reset_monitor_disable,
    input wire logic safe_timeout_disable,
    input wire logic watchdog_reset_enable,
    input wire logic error_monitor_enable,
    input wire logic [3:0] device_error_counter,
    input wire logic logic_test_busy,
    input wire logic logic_test_fail,
    input wire logic analog_test_busy,
    input wire logic analog_test_fail,
    input wire logic clock_loss,
    input wire logic error_pin_fault,
    input wire logic wd_good,
    input wire logic wd_bad,
    input wire logic diag_timeout,
    input wire logic trim_mismatch,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    output logic mcu_reset_out,
    output logic drive_enable_out,
    output logic [2:0] state_code_field
);
    if (US_CYCLES < 2 || US_CYCLES > 256 || US_PER_MS < 2 || US_PER_MS > 1024 ||
        RST_DEG_US < 1 || RST_DEG_US > 127 || DRV_DEG_US < 1 || DRV_DEG_US > 127) begin : g_chk
        $error("ssc_safety_status: parameter out of range");
    end

    ssc_pkg::ssc_regs_t r_ff;
    ssc_pkg::ssc_regs_t nxt_r;
    logic frame_end;
    logic reset_trunc;
    logic lock_reached;
    logic [9:0] safe_lim;

    function automatic logic [2:0] code_of(input ssc_pkg::ssc_state_t s);
        unique case (s)
            ssc_pkg::ST_STANDBY: return `SSC_CODE_STANDBY;
            ssc_pkg::ST_RESET: return `SSC_CODE_RESET;
            ssc_pkg::ST_DIAG: return `SSC_CODE_DIAG;
            ssc_pkg::ST_ACTIVE: return `SSC_CODE_ACTIVE;
            ssc_pkg::ST_SAFE: return `SSC_CODE_SAFE;
            default: return `SSC_CODE_RESET;
        endcase
    endfunction : code_of

    // counts deglitch microseconds while mismatched, drops to zero at once
    function automatic logic [6:0] deg_next(input logic [6:0] cnt, input logic bad,
                                            input logic tick, input logic [6:0] lim);
        if (!bad) return 7'h00;
        if (tick && cnt < lim) return cnt + 7'h01;
        return cnt;
    endfunction : deg_next

    function automatic logic is_read(input logic [6:0] c);
        return c == `SSC_CMD_RD_STAT3 || c == `SSC_CMD_RD_STAT4 ||
               c == `SSC_CMD_RD_STAT5 || c == `SSC_CMD_RD_CFG;
    endfunction : is_read

    always_comb begin
        logic sclk_s;
        logic rise;
        logic fall;
        logic us_tick;
        logic ms_tick;
        logic err_other;
        logic valid;
        logic logic_self_test_done;
        logic analog_self_test_done;
        logic st4_read;
        logic [6:0] op;
        logic [3:0] thr;
        logic [7:0] rd;
        sclk_s = r_ff.sy.sclk[1];
        rise = 1'b0;
        fall = 1'b0;
        us_tick = 1'b0;
        ms_tick = 1'b0;
        err_other = 1'b0;
        valid = 1'b0;
        st4_read = 1'b0;
        logic_self_test_done = 1'b0;
        analog_self_test_done = 1'b0;
        op = r_ff.cmd[7:1];
        thr = r_ff.cfg[`SSC_CFG_THR_MSB:`SSC_CFG_THR_LSB];
        rd = 8'h00;
        nxt_r = r_ff;
        nxt_r.sy.sclk = {r_ff.sy.sclk[0], spi_sclk};
        nxt_r.sy.ncs = {r_ff.sy.ncs[0], spi_ncs_n};
        nxt_r.sy.mosi = {r_ff.sy.mosi[0], spi_mosi};
        nxt_r.sy.sdo_fb = {r_ff.sy.sdo_fb[0], sdo_readback};
        nxt_r.sy.rst_fb = {r_ff.sy.rst_fb[0], mcu_reset_in};
        nxt_r.sy.drv_fb = {r_ff.sy.drv_fb[0], drive_enable_in};

        // time base: microsecond and millisecond ticks
        if (r_ff.us_div == 8'(US_CYCLES - 1)) begin
            nxt_r.us_div = 8'h00;
            us_tick = 1'b1;
        end else begin
            nxt_r.us_div = r_ff.us_div + 8'h01;
        end
        if (us_tick) begin
            if (r_ff.ms_div == 10'(US_PER_MS - 1)) begin
                nxt_r.ms_div = 10'h000;
                ms_tick = 1'b1;
            end else begin
                nxt_r.ms_div = r_ff.ms_div + 10'h001;
            end
        end

        // serial frame: sample on rising clock, shift out on falling clock
        nxt_r.sclk_prev = sclk_s;
        rise = sclk_s && !r_ff.sclk_prev;
        fall = !sclk_s && r_ff.sclk_prev;
        nxt_r.sdo_oe_n = r_ff.sy.ncs[1];
        frame_end = r_ff.sy.ncs[1] && !r_ff.sdo_oe_n;
        reset_trunc = 1'b0;
        unique case (op)
            `SSC_CMD_RD_STAT3: rd = {2'b00, r_ff.rst_err, r_ff.logic_test_error, r_ff.analog_test_error,
                                     r_ff.analog_test_error, r_ff.logic_test_running, r_ff.analog_test_running};
            `SSC_CMD_RD_STAT4: rd = {r_ff.spi_err, r_ff.clk_loss, 1'b0, r_ff.mcu_err,
                                     r_ff.watchdog_error_flag, r_ff.drv_err, r_ff.trim_err};
            `SSC_CMD_RD_STAT5: rd = {5'h00, r_ff.code};
            `SSC_CMD_RD_CFG: rd = r_ff.cfg;
            default: rd = 8'h00;
        endcase
        if (!r_ff.sy.ncs[1] && r_ff.sdo_oe_n) begin
            nxt_r.bit_cnt = 5'h00;
            nxt_r.sdo_bad = 1'b0;
            nxt_r.tx = 8'h00;
            nxt_r.sdo = 1'b0;
        end else if (!r_ff.sy.ncs[1]) begin
            if (rise) begin
                if (r_ff.bit_cnt < `SSC_CMD_BITS) begin
                    nxt_r.cmd = {r_ff.cmd[6:0], r_ff.sy.mosi[1]};
                end else begin
                    nxt_r.data = {r_ff.data[6:0], r_ff.sy.mosi[1]};
                end
                if (r_ff.bit_cnt != 5'h1F) begin
                    nxt_r.bit_cnt = r_ff.bit_cnt + 5'h01;
                end
                if (r_ff.sy.sdo_fb[1] != r_ff.sdo) begin
                    nxt_r.sdo_bad = 1'b1;
                end
            end
            if (fall) begin
                if (r_ff.bit_cnt == `SSC_CMD_BITS) begin
                    nxt_r.sdo = rd[7];
                    nxt_r.tx = {rd[6:0], 1'b0};
                end else begin
                    nxt_r.sdo = r_ff.tx[7];
                    nxt_r.tx = {r_ff.tx[6:0], 1'b0};
                end
            end
        end
        if (frame_end) begin
            // undefined opcodes include writes to read-only registers
            err_other = r_ff.bit_cnt != `SSC_FRAME_BITS || !(^r_ff.cmd) ||
                        !(is_read(op) || op == `SSC_CMD_WR_CFG || op == `SSC_CMD_SOFTWARE_LOCK_COMMAND);
            valid = !err_other && !r_ff.sdo_bad;
            reset_trunc = r_ff.bit_cnt < `SSC_FRAME_BITS && !r_ff.rst_out;
            st4_read = valid && op == `SSC_CMD_RD_STAT4;
            if (reset_trunc) begin
                nxt_r.spi_hold = 1'b1;
            end else if (r_ff.sdo_bad) begin
                nxt_r.spi_err = `SSC_SPI_SDO;
                nxt_r.spi_hold = 1'b0;
            end else if (err_other) begin
                nxt_r.spi_err = `SSC_SPI_FRAME;
                nxt_r.spi_hold = 1'b0;
            end else if (is_read(op)) begin
                nxt_r.spi_err = `SSC_SPI_OK;
                nxt_r.spi_hold = 1'b0;
            end else if (!r_ff.spi_hold) begin
                nxt_r.spi_err = `SSC_SPI_OK;
            end
            if (valid && op == `SSC_CMD_WR_CFG && r_ff.fsm == ssc_pkg::ST_DIAG &&
                !r_ff.software_lock_command && !r_ff.cfg[`SSC_CFG_LOCK_BIT]) begin
                nxt_r.cfg = r_ff.data;
            end
            if (valid && op == `SSC_CMD_SOFTWARE_LOCK_COMMAND) begin
                nxt_r.software_lock_command = 1'b1;
            end
        end

        // readback monitors, deglitched in microseconds
        nxt_r.rst_deg = deg_next(r_ff.rst_deg, r_ff.rst_out && !r_ff.sy.rst_fb[1], us_tick,
                                 7'(RST_DEG_US));
        nxt_r.rst_err = nxt_r.rst_deg >= 7'(RST_DEG_US);
        nxt_r.drv_deg = deg_next(r_ff.drv_deg, r_ff.drv_out != r_ff.sy.drv_fb[1], us_tick,
                                 7'(DRV_DEG_US));
        nxt_r.drv_err = nxt_r.drv_deg >= 7'(DRV_DEG_US);

        // self tests; a failure in the completing cycle wins over the clear
        nxt_r.logic_test_running = logic_test_busy;
        nxt_r.analog_test_running = analog_test_busy;
        logic_self_test_done = r_ff.logic_test_running && !logic_test_busy;
        analog_self_test_done = r_ff.analog_test_running && !analog_test_busy;
        if (logic_test_fail) begin
            nxt_r.logic_test_error = 1'b1;
        end else if (logic_self_test_done) begin
            nxt_r.logic_test_error = 1'b0;
        end
        if (analog_test_fail) begin
            nxt_r.analog_test_error = 1'b1;
        end else if (analog_self_test_done) begin
            nxt_r.analog_test_error = 1'b0;
        end
        nxt_r.clk_loss = clock_loss || analog_self_test_done || (r_ff.clk_loss && !st4_read);
        nxt_r.mcu_err = (error_pin_fault && error_monitor_enable) ||
                        (r_ff.mcu_err && !st4_read);
        nxt_r.trim_err = r_ff.trim_err || trim_mismatch;

        // safe-state time-out; threshold 0 behaves as 15
        if (thr == 4'h0) begin
            thr = `SSC_THR_ZERO_AS;
        end
        lock_reached = {1'b0, device_error_counter} >= {1'b0, thr} + 5'h01;
        safe_lim = lock_reached ? 10'(`SSC_LOCK_MS) :
                   10'({r_ff.cfg[`SSC_CFG_TO_MSB:`SSC_CFG_TO_LSB], 1'b1}) *
                   10'(`SSC_SAFE_UNIT_MS);
        if (r_ff.fsm != ssc_pkg::ST_SAFE) begin
            nxt_r.safe_ms = 10'h000;
        end else if (ms_tick && r_ff.safe_ms != 10'h3FF) begin
            nxt_r.safe_ms = r_ff.safe_ms + 10'h001;
        end

        unique case (r_ff.fsm)
            ssc_pkg::ST_STANDBY: begin
                if (wake) nxt_r.fsm = ssc_pkg::ST_RESET;
            end
            ssc_pkg::ST_RESET: begin
                if (reset_done) nxt_r.fsm = ssc_pkg::ST_DIAG;
            end
            ssc_pkg::ST_DIAG: begin
                if ((r_ff.analog_test_error && !r_ff.analog_test_running) || safe_request) begin
                    nxt_r.fsm = ssc_pkg::ST_SAFE;
                end else if (diag_exit) begin
                    nxt_r.fsm = ssc_pkg::ST_ACTIVE;
                end
            end
            ssc_pkg::ST_ACTIVE: begin
                if (safe_request || (r_ff.rst_err && !reset_monitor_disable) ||
                    (error_pin_fault && error_monitor_enable)) begin
                    nxt_r.fsm = ssc_pkg::ST_SAFE;
                end
            end
            ssc_pkg::ST_SAFE: begin
                if (!(lock_reached && safe_timeout_disable) && r_ff.safe_ms >= safe_lim) begin
                    nxt_r.fsm = ssc_pkg::ST_RESET;
                end
            end
        endcase

        // watchdog fail counter, reloaded on entry to diagnostic or active
        if (nxt_r.fsm != r_ff.fsm &&
            (nxt_r.fsm == ssc_pkg::ST_DIAG || nxt_r.fsm == ssc_pkg::ST_ACTIVE)) begin
            nxt_r.wd_cnt = `SSC_WDCNT_INIT;
        end else if (wd_bad && r_ff.wd_cnt != `SSC_WDCNT_MAX) begin
            nxt_r.wd_cnt = r_ff.wd_cnt + 3'h1;
        end else if (!wd_bad && wd_good && r_ff.wd_cnt != 3'h0) begin
            nxt_r.wd_cnt = r_ff.wd_cnt - 3'h1;
        end
        nxt_r.watchdog_error_flag = (wd_bad && r_ff.wd_cnt == `SSC_WDCNT_MAX && watchdog_reset_enable) ||
                       (diag_timeout && r_ff.fsm == ssc_pkg::ST_DIAG) ||
                       (r_ff.watchdog_error_flag && !st4_read);

        // re-initialisation after the logic self test
        if (logic_self_test_reinit) begin
            nxt_r.fsm = ssc_pkg::ST_RESET;
            nxt_r.wd_cnt = `SSC_WDCNT_INIT;
            nxt_r.spi_err = `SSC_SPI_OK;
            nxt_r.spi_hold = 1'b0;
            nxt_r.clk_loss = 1'b0;
            nxt_r.mcu_err = 1'b0;
            nxt_r.watchdog_error_flag = 1'b0;
        end
        nxt_r.code = code_of(nxt_r.fsm);
        nxt_r.rst_out = nxt_r.fsm == ssc_pkg::ST_DIAG || nxt_r.fsm == ssc_pkg::ST_ACTIVE ||
                        nxt_r.fsm == ssc_pkg::ST_SAFE;
        nxt_r.drv_out = drive_request && nxt_r.fsm == ssc_pkg::ST_ACTIVE &&
                        nxt_r.wd_cnt < `SSC_WDCNT_INIT;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r_ff <= '0;
            r_ff.sy.ncs <= 2'h3;
            r_ff.sdo_oe_n <= 1'b1;
            r_ff.fsm <= ssc_pkg::ST_RESET;
            r_ff.code <= `SSC_CODE_RESET;
            r_ff.cfg <= `SSC_CFG_RESET;
            r_ff.wd_cnt <= `SSC_WDCNT_INIT;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign spi_sdo = r_ff.sdo;
    assign spi_sdo_oe_n = r_ff.sdo_oe_n;
    assign mcu_reset_out = r_ff.rst_out;
    assign drive_enable_out = r_ff.drv_out;
    assign state_code_field = r_ff.code;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    rst_flag_a: assert property (!r_ff.rst_out |=> !r_ff.rst_err)
        else $error("reset error flag without mismatch");
    act_safe_a: assert property (r_ff.fsm == ssc_pkg::ST_ACTIVE && r_ff.rst_err &&
        !reset_monitor_disable && !logic_self_test_reinit |=> r_ff.fsm == ssc_pkg::ST_SAFE)
        else $error("readback error did not force safe");
    diag_safe_a: assert property (r_ff.fsm == ssc_pkg::ST_DIAG && r_ff.analog_test_error &&
        !r_ff.analog_test_running && !logic_self_test_reinit |=> r_ff.fsm == ssc_pkg::ST_SAFE)
        else $error("analog error did not leave diagnostic");
    spi_code_a: assert property (r_ff.spi_err != 2'h2)
        else $error("reserved serial error code");
    sdo_prio_a: assert property (frame_end && r_ff.sdo_bad && !reset_trunc && !logic_self_test_reinit
        |=> r_ff.spi_err == `SSC_SPI_SDO)
        else $error("output mismatch lost priority");
    // a re-initialisation in the completing cycle legally clears the flag
    clk_loss_a: assert property ($fell(r_ff.analog_test_running) && !$past(logic_self_test_reinit)
        |-> r_ff.clk_loss)
        else $error("clock loss not set after analog test");
    code_map_a: assert property (state_code_field == code_of(r_ff.fsm))
        else $error("state code mismatch");
    safe_exit_a: assert property (r_ff.fsm == ssc_pkg::ST_SAFE && !logic_self_test_reinit ##1
        r_ff.fsm == ssc_pkg::ST_RESET |-> $past(r_ff.safe_ms) >= $past(safe_lim))
        else $error("safe state left early");
    safe_lock_a: assert property (r_ff.fsm == ssc_pkg::ST_SAFE && lock_reached &&
        safe_timeout_disable && !logic_self_test_reinit |=> r_ff.fsm == ssc_pkg::ST_SAFE)
        else $error("locked safe state left");
    cfg_lock_a: assert property (r_ff.cfg[`SSC_CFG_LOCK_BIT] |=> $stable(r_ff.cfg))
        else $error("locked configuration changed");
    wd_init_a: assert property ($changed(r_ff.fsm) && r_ff.fsm == ssc_pkg::ST_ACTIVE
        |-> r_ff.wd_cnt == `SSC_WDCNT_INIT)
        else $error("fail counter not reloaded");
    safe_in_c: cover property (r_ff.fsm == ssc_pkg::ST_ACTIVE ##1 r_ff.fsm == ssc_pkg::ST_SAFE);
    safe_out_c: cover property (r_ff.fsm == ssc_pkg::ST_SAFE ##1 r_ff.fsm == ssc_pkg::ST_RESET);
    frame_err_c: cover property (frame_end ##1 r_ff.spi_err == `SSC_SPI_FRAME);
    cfg_wr_c: cover property (frame_end ##1 $changed(r_ff.cfg));
endmodule : ssc_safety_status
`default_nettype wire

// [test/ssc_spi_host.sv]
// serial host model on the far side of the safety block
`default_nettype none
module ssc_spi_host (
    input wire logic clk,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe_n,
    output var logic spi_sclk,
    output var logic spi_ncs_n,
    output var logic spi_mosi,
    output wire logic sdo_readback
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bad = '0;
    // released line reads inverted so a stale value never matches
    assign sdo_readback = spi_sdo ^ (bad | spi_sdo_oe_n);
    initial {spi_sclk, spi_ncs_n, spi_mosi} = 3'h2;
    // mode 0, msb first; sclk stands still between frames
    task automatic xfer(input logic [23:0] w, input int n, input logic c,
                        output logic [7:0] rd);
        bad = c;
        rd = '0;
        @(negedge clk) spi_ncs_n = '0;
        for (int i = 0; i < n; i++) begin
            spi_mosi = w[23 - i];
            repeat (10) @(negedge clk);
            spi_sclk = '1;
            if (i > 7 && i < 16) rd[15 - i] = spi_sdo;
            repeat (10) @(negedge clk);
            spi_sclk = '0;
        end
        repeat (10) @(negedge clk);
        {spi_ncs_n, bad} = 2'h2;
        repeat (10) @(negedge clk);
    endtask : xfer
endmodule : ssc_spi_host
`default_nettype wire

// [test/test_safety_status_and_safe_state_cfg.sv]
// self-checking bench of the safety status block
`default_nettype none
`include "ssc_defines.svh"
module test_safety_status_and_safe_state_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] R3 = `SSC_CMD_RD_STAT3, R4 = `SSC_CMD_RD_STAT4;
    localparam logic [6:0] R5 = `SSC_CMD_RD_STAT5, RC = `SSC_CMD_RD_CFG;
    logic clk = '0, reset_n = '0, logic_self_test_reinit = '0, wake = '0, reset_done = '0;
    logic diag_exit = '0, safe_request = '0, drive_request = '0, wd_good = '0;
    logic reset_monitor_disable = '0, safe_timeout_disable = '0, wd_bad = '0;
    logic watchdog_reset_enable = '0, error_monitor_enable = '0, rst_fault = '0;
    logic logic_test_busy = '0, logic_test_fail = '0, analog_test_busy = '0;
    logic analog_test_fail = '0, clock_loss = '0, error_pin_fault = '0;
    logic diag_timeout = '0, trim_mismatch = '0, drv_fault = '0;
    logic [3:0] device_error_counter = 4'h1;
    logic [7:0] rd;
    int fails = 0, checked = 0;
    time t0;
    wire logic spi_sclk, spi_ncs_n, spi_mosi, sdo_readback, spi_sdo, spi_sdo_oe_n;
    wire logic mcu_reset_out, drive_enable_out;
    wire logic [2:0] state_code_field;
    // board readback; a fault pulls the reset line low
    wire logic mcu_reset_in = mcu_reset_out & ~rst_fault;
    wire logic drive_enable_in = drive_enable_out ^ drv_fault;
    // rows {logic busy, logic fail, analog busy, analog fail} and result
    logic [3:0] st_in [4] = '{4'hC, 4'h8, 4'h3, 4'h2};
    logic [7:0] st_exp [4] = '{8'h10, 8'h00, 8'h0C, 8'h00};
    // odd frames: word, bits, corrupt readback, code left behind
    logic [23:0] bw [5] = '{24'h280000, 24'h290000, 24'h290000, 24'h010000, 24'h290000};
    int bn [5] = '{16, 8, 17, 16, 17};
    logic [4:0] bc = 5'h10;
    logic [7:0] be [5] = '{8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'h40};

    ssc_safety_status #(.US_CYCLES(4), .US_PER_MS(4), .RST_DEG_US(3), .DRV_DEG_US(3)
    ) ssc_safety_status_i (
        .clk, .reset_n, .logic_self_test_reinit, .spi_sclk, .spi_ncs_n, .spi_mosi, .sdo_readback,
        .mcu_reset_in, .drive_enable_in, .wake, .reset_done, .diag_exit, .safe_request,
        .drive_request, .reset_monitor_disable, .safe_timeout_disable,
        .watchdog_reset_enable, .error_monitor_enable, .device_error_counter,
        .logic_test_busy, .logic_test_fail, .analog_test_busy, .analog_test_fail,
        .clock_loss, .error_pin_fault, .wd_good, .wd_bad, .diag_timeout, .trim_mismatch,
        .spi_sdo, .spi_sdo_oe_n, .mcu_reset_out, .drive_enable_out, .state_code_field
    );
    ssc_spi_host ssc_spi_host_i (
        .clk, .spi_sdo, .spi_sdo_oe_n, .spi_sclk, .spi_ncs_n, .spi_mosi, .sdo_readback
    );

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rreg(input logic [6:0] op, input logic [7:0] exp, input logic [7:0] m);
        ssc_spi_host_i.xfer({op, ~^op, 16'h0000}, 16, 1'h0, rd);
        cmp(rd & m, exp);
    endtask : rreg
    task automatic wreg(input logic [7:0] d);
        ssc_spi_host_i.xfer({`SSC_CMD_WR_CFG, ~^`SSC_CMD_WR_CFG, d, 8'h00}, 16, 1'h0, rd);
    endtask : wreg
    task automatic pulse(ref logic s);
        @(negedge clk) s = '1;
        @(negedge clk) s = '0;
    endtask : pulse
    task automatic wait_code(input logic [2:0] c, input int lim);
        int k = 0;
        while (state_code_field !== c && k < lim) begin
            @(negedge clk);
            k++;
        end
        cmp({5'h00, state_code_field}, {5'h00, c});
    endtask : wait_code
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial forever #2 clk = ~clk;
    initial begin
        #300000;
        fails++;
        test_done();
    end
    initial begin
        repeat (20) @(negedge clk);
        wait_code(`SSC_CODE_RESET, 0);
        cmp({6'h00, mcu_reset_out, spi_sdo_oe_n}, 8'h01);
        reset_n = '1;
        repeat (4) @(negedge clk);
        rreg(R5, 8'h03, 8'hFF);
        ssc_spi_host_i.xfer(bw[4], 17, 1'h1, rd);
        ssc_spi_host_i.xfer(bw[1], 8, 1'h0, rd);
        wreg(8'h00);
        rreg(R4, 8'h40, 8'hFF);
        pulse(reset_done);
        wait_code(`SSC_CODE_DIAG, 4);
        cmp({7'h00, mcu_reset_out}, 8'h01);
        wreg(8'h20);
        rreg(RC, 8'h20, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            ssc_spi_host_i.xfer(bw[i], bn[i], bc[i], rd);
            rreg(R4, be[i], 8'hFF);
        end
        pulse(error_pin_fault);
        {watchdog_reset_enable, error_monitor_enable} = 2'h3;
        pulse(clock_loss);
        pulse(error_pin_fault);
        repeat (3) pulse(wd_bad);
        trim_mismatch = '1;
        rreg(R4, 8'h2D, 8'hFF);
        trim_mismatch = '0;
        rreg(R4, 8'h01, 8'hFF);
        pulse(diag_timeout);
        rreg(R4, 8'h05, 8'hFF);
        pulse(diag_exit);
        wait_code(`SSC_CODE_ACTIVE, 4);
        wreg(8'hE0);
        rreg(RC, 8'h20, 8'hFF);
        for (int r = 0; r < 4; r++) begin
            @(negedge clk);
            {logic_test_busy, logic_test_fail, analog_test_busy, analog_test_fail} = st_in[r];
            rreg(R3, {6'h00, st_in[r][3], st_in[r][1]}, 8'h03);
            {logic_test_busy, analog_test_busy} = 2'h0;
            rreg(R3, st_exp[r], 8'hFF);
        end
        rreg(R4, 8'h21, 8'hFF);
        drive_request = '1;
        pulse(wd_good);
        cmp({7'h00, drive_enable_out}, 8'h01);
        drv_fault = '1;
        rreg(R4, 8'h03, 8'hFF);
        {drive_request, drv_fault} = 2'h0;
        rreg(R4, 8'h01, 8'hFF);
        {reset_monitor_disable, rst_fault} = 2'h3;
        rreg(R3, 8'h20, 8'hFF);
        wait_code(`SSC_CODE_ACTIVE, 0);
        reset_monitor_disable = '0;
        wait_code(`SSC_CODE_SAFE, 4);
        t0 = $time;
        rst_fault = '0;
        rreg(R3, 8'h00, 8'hFF);
        wait_code(`SSC_CODE_RESET, 1100);
        cmp({7'h00, ($time - t0) / 4 inside {[1030:1075]}}, 8'h01);
        pulse(reset_done);
        wait_code(`SSC_CODE_DIAG, 4);
        wreg(8'h23);
        wreg(8'hE0);
        rreg(RC, 8'h23, 8'hFF);
        device_error_counter = 4'h2;
        safe_timeout_disable = '1;
        pulse(safe_request);
        repeat (12000) @(negedge clk);
        wait_code(`SSC_CODE_SAFE, 0);
        safe_timeout_disable = '0;
        wait_code(`SSC_CODE_RESET, 8);
        // fixed lock time-out: 680 ms of 16 cycles each, within one tick
        pulse(reset_done);
        wait_code(`SSC_CODE_DIAG, 4);
        pulse(safe_request);
        t0 = $time;
        wait_code(`SSC_CODE_RESET, 11000);
        cmp({7'h00, ($time - t0) / 4 inside {[10860:10890]}}, 8'h01);
        pulse(reset_done);
        wait_code(`SSC_CODE_DIAG, 4);
        pulse(logic_self_test_reinit);
        wait_code(`SSC_CODE_RESET, 0);
        cmp({7'h00, mcu_reset_out}, 8'h00);
        test_done();
    end
endmodule : test_safety_status_and_safe_state_cfg
`default_nettype wire
